// ### core/bdmm_pkg.sv
// package: constants and types for the banked data memory map
package bdmm_pkg;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 9;
    localparam int GP_BYTES = 336;
    localparam int GP_IDX_W = 9;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INTR_VECTOR = 13'h0004;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PCLATCH = 7'h0a;
    localparam logic [6:0] OFS_GP0_FIRST = 7'h20;
    localparam logic [6:0] OFS_GP_FIRST = 7'h20;
    localparam logic [6:0] OFS_GPB_FIRST = 7'h20;
    localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;
    localparam logic [6:0] OFS_BANK_LAST = 7'h7f;
    localparam logic [6:0] BANK0_GP_COUNT = 7'h50;
    localparam logic [8:0] BANK_GP_COUNT = 9'h050;
    localparam logic [8:0] COMMON_BASE = 9'h140;
    localparam int ST_POINTER_BANK = 7;
    localparam int ST_BANK_HI = 6;
    localparam int ST_BANK_LO = 5;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_POWERDOWN = 3;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] STATUS_FLAG_MASK = 8'he7;
    localparam logic [4:0] PCLATCH_RESET = 5'h00;
    // avalon byte addresses of the core control registers
    localparam logic [7:0] AV_FILE_ADDR = 8'h00;
    localparam logic [7:0] AV_FILE_DATA = 8'h04;
    localparam logic [7:0] AV_PC = 8'h08;
    localparam logic [7:0] AV_CONTROL = 8'h0c;
    localparam logic [31:0] AV_UNMAPPED = 32'hdead_beef;
    typedef enum logic [1:0] {BDMM_IDLE, BDMM_ACK} bdmm_state_t;
endpackage

// ### core/bdmm_gp_store.sv
// general-purpose byte storage, flip-flop array with one write port
`timescale 1ns/10ps
module bdmm_gp_store
    import bdmm_pkg::*;
#(
    parameter int DEPTH = GP_BYTES
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic [GP_IDX_W-1:0] idx,
    input wire logic [DATA_W-1:0] wrData,
    output logic [DATA_W-1:0] rdData
);
    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
    } bdmm_store_t;
    bdmm_store_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (wrEn && idx < GP_IDX_W'(DEPTH)) begin
            s_d.mem[idx] = wrData;
        end
    end
    always_ff @(posedge clk) begin
        if (ce) begin
            s_q <= s_d;
        end
    end
    assign rdData = (idx < GP_IDX_W'(DEPTH)) ? s_q.mem[idx] : '0;
endmodule

// ### core/bdmm_top.sv
// banked data memory map: pc, status, pointer and banked byte storage
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module bdmm_top
    import bdmm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWriteData,
    input wire logic [3:0] avByteEnable,
    output logic [31:0] avReadData,
    output logic avWaitRequest,
    input wire logic fetchAdvance,
    input wire logic intrTake,
    output logic [PC_W-1:0] fetchAddr
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        bdmm_state_t st;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] pointer;
        logic [4:0] pcLatch;
        logic [FILE_ADDR_W-1:0] fileAddr;
        logic [31:0] rdData;
        logic waitReq;
    } bdmm_regs_t;
    bdmm_regs_t r_q, r_d;

    // ****************************************
    // address decode
    // ****************************************
    // storage index for a 9-bit file address; valid flag in msb
    function automatic logic [GP_IDX_W:0] gpIndex(input logic [FILE_ADDR_W-1:0] fa);
        logic [1:0] bank;
        logic [6:0] ofs;
        logic [8:0] base;
        bank = fa[8:7];
        ofs = fa[6:0];
        base = '0;
        if (ofs >= OFS_COMMON_FIRST) begin
            return {1'b1, COMMON_BASE + {2'b00, ofs - OFS_COMMON_FIRST}};
        end
        if (ofs < OFS_GP_FIRST) begin
            return '0;
        end
        if (bank == 2'd0) begin
            return {1'b1, {2'b00, ofs - OFS_GP0_FIRST}};
        end
        base = 9'(BANK0_GP_COUNT) + 9'(bank - 2'd1) * BANK_GP_COUNT;
        return {1'b1, base + {2'b00, ofs - OFS_GPB_FIRST}};
    endfunction

    logic [FILE_ADDR_W-1:0] effAddr;
    logic [GP_IDX_W:0] gpSel;
    logic [DATA_W-1:0] gpRd;
    logic gpWr;
    logic [DATA_W-1:0] wrByte;
    logic fileWr;
    logic [DATA_W-1:0] fileRd;
    logic reqLive;

    always_comb begin
        // indirect window goes through pointer and pointer bank bit
        if (r_q.fileAddr[6:0] == OFS_INDIRECT) begin
            effAddr = {r_q.status[ST_POINTER_BANK], r_q.pointer};
        end else begin
            effAddr = r_q.fileAddr;
        end
    end

    assign gpSel = gpIndex(effAddr);
    assign wrByte = avWriteData[7:0];
    // request still held in the answer cycle: writes commit there
    assign reqLive = (avRead || avWrite) && r_q.st == BDMM_ACK;
    assign fileWr = reqLive && avWrite && avAddress == AV_FILE_DATA && avByteEnable[0];
    assign gpWr = fileWr && gpSel[GP_IDX_W];

    bdmm_gp_store #(
        .DEPTH(GP_BYTES)
    ) u_store (
        .clk(clk),
        .ce(ce),
        .wrEn(gpWr),
        .idx(gpSel[GP_IDX_W-1:0]),
        .wrData(wrByte),
        .rdData(gpRd)
    );

    always_comb begin
        // core registers mirrored in all banks: offset only
        unique case (effAddr[6:0])
            OFS_PCL: fileRd = r_q.pc[7:0];
            OFS_STATUS: fileRd = r_q.status;
            OFS_POINTER: fileRd = r_q.pointer;
            OFS_PCLATCH: fileRd = {3'b000, r_q.pcLatch};
            default: fileRd = gpSel[GP_IDX_W] ? gpRd : '0;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        r_d = r_q;
        r_d.waitReq = 1'b1;
        if (intrTake) begin
            r_d.pc = INTR_VECTOR;
        end else if (fetchAdvance) begin
            r_d.pc = PC_W'(r_q.pc + 13'h0001);
        end
        unique case (r_q.st)
            BDMM_IDLE: begin
                if (avRead || avWrite) begin
                    r_d.st = BDMM_ACK;
                    r_d.waitReq = 1'b0;
                    if (avRead) begin
                        unique case (avAddress)
                            AV_FILE_ADDR: r_d.rdData = 32'(r_q.fileAddr);
                            AV_FILE_DATA: r_d.rdData = 32'(fileRd);
                            AV_PC: r_d.rdData = 32'(r_q.pc);
                            AV_CONTROL: r_d.rdData = 32'({r_q.status[ST_BANK_HI:ST_BANK_LO]});
                            default: r_d.rdData = AV_UNMAPPED;
                        endcase
                    end
                end
            end
            BDMM_ACK: begin
                // writes land at the edge where the master sees the answer
                r_d.st = BDMM_IDLE;
                if (avWrite && avAddress == AV_FILE_ADDR && avByteEnable[0]) begin
                    // software gives offset; bank comes from status unless lane 1 sets bit 8 for an absolute file address
                    r_d.fileAddr = {r_q.status[ST_BANK_HI:ST_BANK_LO], wrByte[6:0]};
                    if (avByteEnable[1] && avWriteData[8]) begin
                        r_d.fileAddr = avWriteData[FILE_ADDR_W-1:0];
                    end
                end else if (fileWr) begin
                    unique case (effAddr[6:0])
                        OFS_PCL: begin
                            r_d.pc = {r_q.pcLatch, wrByte};
                        end
                        OFS_STATUS: begin
                            // timeout and powerdown are read-only
                            r_d.status = (wrByte & STATUS_FLAG_MASK) |
                                (r_q.status & ~STATUS_FLAG_MASK);
                        end
                        OFS_POINTER: r_d.pointer = wrByte;
                        OFS_PCLATCH: r_d.pcLatch = wrByte[4:0];
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_q.st <= BDMM_IDLE;
            r_q.pc <= RESET_VECTOR;
            r_q.status <= STATUS_RESET;
            r_q.pointer <= '0;
            r_q.pcLatch <= PCLATCH_RESET;
            r_q.fileAddr <= '0;
            r_q.rdData <= '0;
            r_q.waitReq <= 1'b1;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign avReadData = r_q.rdData;
    assign avWaitRequest = r_q.waitReq;
    assign fetchAddr = r_q.pc;

    // ****************************************
    // checks
    // ****************************************
    a_reset_vector: assert property (@(posedge clk) $fell(rst) |-> fetchAddr == RESET_VECTOR)
        else $error("pc not at reset vector");
    a_intr_vector: assert property (@(posedge clk) disable iff (rst)
        ce && intrTake |=> fetchAddr == INTR_VECTOR)
        else $error("interrupt vector missed");
    a_pc_wraps: assert property (@(posedge clk) disable iff (rst)
        ce && !intrTake && fetchAdvance && r_q.st == BDMM_IDLE && fetchAddr == 13'h1fff
        |=> fetchAddr == 13'h0000)
        else $error("pc not 13 bits");
    a_status_ro: assert property (@(posedge clk) disable iff (rst)
        ce |=> r_q.status[ST_TIMEOUT:ST_POWERDOWN] == $past(r_q.status[ST_TIMEOUT:ST_POWERDOWN]))
        else $error("status read-only bits changed");
    a_common_map: assert property (@(posedge clk)
        gpIndex({2'd3, OFS_COMMON_FIRST}) == gpIndex({2'd0, OFS_COMMON_FIRST}))
        else $error("common region not shared");
    a_gp_range: assert property (@(posedge clk)
        gpIndex({2'd3, OFS_COMMON_FIRST - 7'h01}) == {1'b1, 9'(GP_BYTES - 17)})
        else $error("storage index out of range");
    a_sfr_no_gp: assert property (@(posedge clk)
        !gpSel[GP_IDX_W] || effAddr[6:0] >= OFS_GP_FIRST)
        else $error("control offset mapped to storage");
    a_wait_one: assert property (@(posedge clk) disable iff (rst)
        ce && r_q.st == BDMM_IDLE && (avRead || avWrite) |=> !avWaitRequest ##1 avWaitRequest)
        else $error("bus answer timing wrong");
    a_bank_addr: assert property (@(posedge clk) disable iff (rst)
        ce && reqLive && avWrite && avAddress == AV_FILE_ADDR && avByteEnable == 4'h1
        |=> r_q.fileAddr[8:7] == $past(r_q.status[ST_BANK_HI:ST_BANK_LO]))
        else $error("bank select not used");

    // ****************************************
    // program counter, register and bus checks
    // ****************************************
    a_ce_freeze: assert property (
        @(posedge clk) disable iff (rst)
        !ce
        |=> $stable(fetchAddr) && $stable(avWaitRequest) && $stable(avReadData))
        else $error("state moved while clock enable low");
    a_pc_advance: assert property (
        @(posedge clk) disable iff (rst)
        ce && !intrTake && fetchAdvance && r_q.st == BDMM_IDLE
        |=> fetchAddr == PC_W'($past(fetchAddr) + 13'h0001))
        else $error("pc did not advance by one");
    a_pc_hold: assert property (
        @(posedge clk) disable iff (rst)
        ce && !intrTake && !fetchAdvance && r_q.st == BDMM_IDLE
        |=> $stable(fetchAddr))
        else $error("pc moved without cause");
    a_pcl_load: assert property (
        @(posedge clk) disable iff (rst)
        ce && fileWr && effAddr[6:0] == OFS_PCL
        |=> fetchAddr == {$past(r_q.pcLatch), $past(wrByte)})
        else $error("pc low write did not load latch and byte");
    a_latch_write: assert property (
        @(posedge clk) disable iff (rst)
        ce && fileWr && effAddr[6:0] == OFS_PCLATCH
        |=> r_q.pcLatch == $past(wrByte[4:0]))
        else $error("pc upper latch write lost");
    a_status_write: assert property (
        @(posedge clk) disable iff (rst)
        ce && fileWr && effAddr[6:0] == OFS_STATUS
        |=> r_q.status[ST_POINTER_BANK:ST_BANK_LO] == $past(wrByte[7:5]))
        else $error("bank bits not written");
    a_status_reset: assert property (
        @(posedge clk)
        $fell(rst)
        |-> r_q.status == STATUS_RESET)
        else $error("status not at reset value");
    a_pointer_hold: assert property (
        @(posedge clk) disable iff (rst)
        ce && !(fileWr && effAddr[6:0] == OFS_POINTER)
        |=> $stable(r_q.pointer))
        else $error("pointer changed without a write");
    a_gp_write: assert property (
        @(posedge clk)
        gpWr
        |-> gpSel[GP_IDX_W-1:0] < GP_IDX_W'(GP_BYTES))
        else $error("storage write out of range");
    a_mirror_read: assert property (
        @(posedge clk)
        effAddr[6:0] == OFS_STATUS
        |-> fileRd == r_q.status)
        else $error("status not mirrored in this bank");
    a_pc_read: assert property (
        @(posedge clk) disable iff (rst)
        ce && r_q.st == BDMM_IDLE && avRead && avAddress == AV_PC
        |=> avReadData == 32'($past(fetchAddr)))
        else $error("pc read returned wrong value");
    a_unmapped_read: assert property (
        @(posedge clk) disable iff (rst)
        ce && r_q.st == BDMM_IDLE && avRead && avAddress != AV_FILE_ADDR &&
        avAddress != AV_FILE_DATA && avAddress != AV_PC && avAddress != AV_CONTROL
        |=> avReadData == AV_UNMAPPED)
        else $error("unmapped read not flagged");
    a_wait_reset: assert property (
        @(posedge clk)
        rst
        |=> avWaitRequest)
        else $error("waitrequest low after reset");
    a_ack_one: assert property (
        @(posedge clk) disable iff (rst)
        ce && r_q.st == BDMM_ACK
        |=> r_q.st == BDMM_IDLE)
        else $error("answer state held too long");
    a_read_hold: assert property (
        @(posedge clk) disable iff (rst)
        !(ce && r_q.st == BDMM_IDLE && avRead)
        |=> $stable(avReadData))
        else $error("read data changed without a read");
    a_abs_addr: assert property (
        @(posedge clk) disable iff (rst)
        ce && reqLive && avWrite && avAddress == AV_FILE_ADDR && avByteEnable[1:0] == 2'b11
        && avWriteData[8] |=> r_q.fileAddr == $past(avWriteData[FILE_ADDR_W-1:0]))
        else $error("absolute file address not taken");
    c_read: cover property (@(posedge clk) avRead && !avWaitRequest);
    c_write: cover property (@(posedge clk) avWrite && !avWaitRequest);
    c_intr: cover property (@(posedge clk) intrTake && ce);
    c_indirect: cover property (@(posedge clk) gpWr && r_q.fileAddr[6:0] == OFS_INDIRECT);
    c_absolute: cover property (@(posedge clk) reqLive && avWrite && avByteEnable[1]);
endmodule

// ### tb/bdmm_cpu_model.sv
// cpu-side model: avalon master issuing operand accesses to the memory map
`timescale 1ns/10ps
module bdmm_cpu_model (
    input wire logic clk,
    input wire logic avWaitRequest,
    input wire logic [31:0] avReadData,
    output logic [7:0] avAddress,
    output logic avRead,
    output logic avWrite,
    output logic [31:0] avWriteData,
    output logic [3:0] avByteEnable
);
    initial begin
        avAddress = 8'h00;
        avRead = 1'b0;
        avWrite = 1'b0;
        avWriteData = 32'h0000_0000;
        avByteEnable = 4'h1;
    end
    // call at a rising edge; returns one edge after release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        avAddress <= a;
        avWrite <= wr;
        avRead <= !wr;
        avWriteData <= d;
        // lane 1 only for an absolute file address
        avByteEnable <= (wr && a == 8'h00 && d[8]) ? 4'h3 : 4'h1;
        do begin
            @(posedge clk);
        end while (avWaitRequest !== 1'b0);
        q = avReadData;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        // released lines must not look like the last value
        avAddress <= ~a;
        avWriteData <= ~d;
        @(posedge clk);
    endtask
endmodule

// ### tb/banked_data_memory_map_bench.sv
// self-checking bench for the banked data memory map
`timescale 1ns/10ps
module banked_data_memory_map_bench;
    import bdmm_pkg::*;
    typedef struct packed {logic [1:0] bank; logic [6:0] ofs; logic [7:0] data;} bdmm_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic fetchAdvance = 1'b0;
    logic intrTake = 1'b0;
    logic [7:0] avAddress;
    logic avRead;
    logic avWrite;
    logic [31:0] avWriteData;
    logic [3:0] avByteEnable;
    logic [31:0] avReadData;
    logic avWaitRequest;
    logic [12:0] fetchAddr;
    logic [31:0] rdq;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    bdmm_row_t rows [6] = '{'{2'd0, 7'h20, 8'h11}, '{2'd1, 7'h20, 8'h22},
        '{2'd2, 7'h20, 8'h33}, '{2'd3, 7'h20, 8'h44}, '{2'd3, 7'h6f, 8'ha5},
        '{2'd2, 7'h70, 8'h5a}};
    always #25 clk = ~clk;
    bdmm_top dut (.clk(clk), .rst(rst), .ce(ce), .avAddress(avAddress), .avRead(avRead),
        .avWrite(avWrite), .avWriteData(avWriteData), .avByteEnable(avByteEnable),
        .avReadData(avReadData), .avWaitRequest(avWaitRequest),
        .fetchAdvance(fetchAdvance), .intrTake(intrTake), .fetchAddr(fetchAddr));
    bdmm_cpu_model cpu (.clk(clk), .avWaitRequest(avWaitRequest), .avReadData(avReadData),
        .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
        .avWriteData(avWriteData), .avByteEnable(avByteEnable));
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fwr(input logic [6:0] ofs, input logic [7:0] d);
        cpu.xfer(1'b1, AV_FILE_ADDR, 32'(ofs), rdq);
        cpu.xfer(1'b1, AV_FILE_DATA, 32'(d), rdq);
    endtask
    task automatic frd(input logic [6:0] ofs);
        cpu.xfer(1'b1, AV_FILE_ADDR, 32'(ofs), rdq);
        cpu.xfer(1'b0, AV_FILE_DATA, 32'h0000_0000, rdq);
        rdq = 32'(rdq[7:0]);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(32'(fetchAddr), 32'(RESET_VECTOR));
        @(posedge clk);
        frd(OFS_STATUS);
        check(rdq, 32'(STATUS_RESET));
        foreach (rows[i]) begin
            fwr(OFS_STATUS, {1'b0, rows[i].bank, 5'h00});
            fwr(rows[i].ofs, rows[i].data);
        end
        foreach (rows[i]) begin
            fwr(OFS_STATUS, {1'b0, rows[i].bank, 5'h00});
            frd(rows[i].ofs);
            check(rdq, 32'(rows[i].data));
        end
        cpu.xfer(1'b1, AV_FILE_ADDR, 32'h0000_01a0, rdq);
        cpu.xfer(1'b0, AV_FILE_DATA, 32'h0000_0000, rdq);
        check(32'(rdq[7:0]), 32'h0000_0044);
        frd(OFS_STATUS);
        check(rdq, 32'h0000_0058);
        fwr(OFS_STATUS, 8'h00);
        frd(7'h70);
        check(rdq, 32'h0000_005a);
        fwr(OFS_POINTER, 8'h20);
        frd(OFS_INDIRECT);
        check(rdq, 32'h0000_0011);
        fwr(OFS_POINTER, 8'ha0);
        frd(OFS_INDIRECT);
        check(rdq, 32'h0000_0022);
        cpu.xfer(1'b0, 8'h10, 32'h0000_0000, rdq);
        check(rdq, AV_UNMAPPED);
        fwr(OFS_PCLATCH, 8'h1f);
        fwr(OFS_PCL, 8'hff);
        check(32'(fetchAddr), 32'h0000_1fff);
        fetchAdvance <= 1'b1;
        @(posedge clk);
        fetchAdvance <= 1'b0;
        #1;
        check(32'(fetchAddr), 32'h0000_0000);
        @(posedge clk);
        fetchAdvance <= 1'b1;
        repeat (3) @(posedge clk);
        fetchAdvance <= 1'b0;
        #1;
        check(32'(fetchAddr), 32'h0000_0003);
        @(posedge clk);
        fetchAdvance <= 1'b1;
        intrTake <= 1'b1;
        @(posedge clk);
        fetchAdvance <= 1'b0;
        intrTake <= 1'b0;
        #1;
        check(32'(fetchAddr), 32'(INTR_VECTOR));
        @(posedge clk);
        ce <= 1'b0;
        fetchAdvance <= 1'b1;
        repeat (2) @(posedge clk);
        fetchAdvance <= 1'b0;
        ce <= 1'b1;
        #1;
        check(32'(fetchAddr), 32'(INTR_VECTOR));
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check(32'(fetchAddr), 32'(RESET_VECTOR));
        @(posedge clk);
        frd(OFS_STATUS);
        check(rdq, 32'(STATUS_RESET));
        summarize();
    end
endmodule
